//--- hw/dbg_pins.sv
// Purpose: debug serial port pins, breakpoint pin and real-time trace port
// Assumes: core supplies instruction starts, capture words and a tx bit
// Notes:   trace clock is built from a rising and a falling edge flop
`timescale 1ns/100ps
`include "dbg_consts.svh"
module dbg_pins
  import dbg_pins_pkg::*;
#(
  parameter int DATA_W = `DBG_DATA_W
) (
  input  wire logic              clock_in,              // core clock
  input  wire logic              reset_in,              // sync reset
  input  wire logic              debug_serial_clock_in, // serial clock pin
  input  wire logic              debug_serial_in_in,    // serial data pin
  output logic                   debug_serial_out_out,  // serial data pin
  input  wire logic              serial_tx_bit_in,      // next bit to send
  output logic                   serial_rx_bit_out,     // sampled bit
  output logic                   serial_rx_valid_out,   // sample pulse
  input  wire logic              breakpoint_request_in, // breakpoint pin
  input  wire logic              breakpoint_to_interrupt_in, // irq mode
  input  wire logic              trace_quiet_in,        // freeze trace
  input  wire logic              capture_enable_in,     // show captures
  input  wire logic              instr_start_in,        // first cycle
  input  wire dbg_pins_pkg::dbg_nib_t core_code_in,     // special code
  input  wire logic              instr_done_in,         // instr completes
  input  wire logic              resume_in,             // leave halt
  input  wire dbg_pins_pkg::dbg_nib_t breakpoint_request_status_in,   // trigger status
  input  wire logic              capture_valid_in,      // capture word
  input  wire logic [DATA_W-1:0] capture_data_in,       // capture data
  input  wire dbg_pins_pkg::dbg_len_t capture_bytes_in, // bytes minus 1
  input  wire logic              write_debug_data_instr_valid_in,       // write-data instr
  output logic                   core_halt_out,         // core halted
  output logic                   debug_irq_out,         // irq pulse
  output logic                   core_stall_out,        // buffer full
  output logic                   trace_clock_out,       // trace clock pin
  output dbg_pins_pkg::dbg_nib_t processor_status_nibble_out, // status
  output dbg_pins_pkg::dbg_nib_t debug_data_nibble_out  // data
);
  import dbg_pins_pkg::*;

  localparam int PW = $clog2(`DBG_FIFO_DEPTH);

  // synchronised pins
  logic [2:0] pins_s;
  logic       sclk_s;
  logic       sdin_s;
  logic       breakpoint_request_s;

  // pin synchroniser, serial clock, serial input and breakpoint
  dbg_sync #(
    .WIDTH (3)
  ) u_sync (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in ({breakpoint_request_in, debug_serial_in_in,
                debug_serial_clock_in}),
    .sync_out (pins_s)
  );
  assign sclk_s = pins_s[0];
  assign sdin_s = pins_s[1];
  assign breakpoint_request_s = pins_s[2];

  // serial port state
  logic sclk_prev_q, sclk_prev_d;
  logic sout_q, sout_d;
  logic rxb_q, rxb_d;
  logic rxv_q, rxv_d;
  logic sclk_rise;

  // act on synchronised rising edge of the serial clock
  always_comb begin
    sclk_rise   = sclk_s & ~sclk_prev_q;
    sclk_prev_d = sclk_s;
    sout_d      = sout_q;
    rxb_d       = rxb_q;
    rxv_d       = 1'b0;
    if (sclk_rise) begin
      rxb_d  = sdin_s;
      rxv_d  = 1'b1;
      sout_d = serial_tx_bit_in;
    end
  end

  // serial registers
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sclk_prev_q <= 1'b0;
      sout_q      <= 1'b0;
      rxb_q       <= 1'b0;
      rxv_q       <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_prev_d;
      sout_q      <= sout_d;
      rxb_q       <= rxb_d;
      rxv_q       <= rxv_d;
    end
  end

  // breakpoint state
  logic breakpoint_request_prev_q, breakpoint_request_prev_d;
  logic pend_q, pend_d;
  logic halt_q, halt_d;
  logic irq_q, irq_d;
  logic breakpoint_request_rise;

  // halt after current instruction, or raise debug interrupt
  always_comb begin
    breakpoint_request_rise   = breakpoint_request_s & ~breakpoint_request_prev_q;
    breakpoint_request_prev_d = breakpoint_request_s;
    pend_d      = pend_q;
    halt_d      = halt_q;
    irq_d       = breakpoint_request_rise & breakpoint_to_interrupt_in;
    if (breakpoint_request_s && !breakpoint_to_interrupt_in && !halt_q) begin
      pend_d = 1'b1;
    end
    if ((pend_q || pend_d) && instr_done_in) begin
      halt_d = 1'b1;
      pend_d = 1'b0;
    end else if (halt_q && resume_in) begin
      halt_d = 1'b0;
    end
  end

  // breakpoint registers
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      breakpoint_request_prev_q <= 1'b0;
      pend_q      <= 1'b0;
      halt_q      <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      breakpoint_request_prev_q <= breakpoint_request_prev_d;
      pend_q      <= pend_d;
      halt_q      <= halt_d;
      irq_q       <= irq_d;
    end
  end

  // capture buffer and shifter state
  logic [DATA_W-1:0] mem_q [`DBG_FIFO_DEPTH];
  logic [DATA_W-1:0] mem_d [`DBG_FIFO_DEPTH];
  dbg_len_t          len_q [`DBG_FIFO_DEPTH];
  dbg_len_t          len_d [`DBG_FIFO_DEPTH];
  logic [PW-1:0]     wp_q, wp_d, rp_q, rp_d;
  logic [PW:0]       cnt_q, cnt_d;
  logic              stall_q, stall_d;
  logic [DATA_W-1:0] sh_q, sh_d;
  dbg_len_t          shlen_q, shlen_d;
  logic [2:0]        nib_q, nib_d;
  dbg_shift_state_t  st_q, st_d;
  logic              push, pop, mark_now;

  // buffer fill and drain, marker and nibble shifting
  always_comb begin
    mem_d    = mem_q;
    len_d    = len_q;
    wp_d     = wp_q;
    rp_d     = rp_q;
    sh_d     = sh_q;
    shlen_d  = shlen_q;
    nib_d    = nib_q;
    st_d     = st_q;
    push     = (write_debug_data_instr_valid_in ||
                (capture_valid_in && capture_enable_in)) &&
               (cnt_q != (PW+1)'(`DBG_FIFO_DEPTH));
    mark_now = (st_q == DS_IDLE) && (cnt_q != '0) &&
               !instr_start_in && !halt_q;
    pop      = mark_now;
    if (push) begin
      mem_d[wp_d] = capture_data_in;
      len_d[wp_d] = capture_bytes_in;
      wp_d        = wp_q + 1'b1;
    end
    case (st_q)
      DS_IDLE: begin
        if (mark_now) begin
          sh_d    = mem_q[rp_q];
          shlen_d = len_q[rp_q];
          nib_d   = {len_q[rp_q], 1'b1};                    // 2*bytes-1
          rp_d    = rp_q + 1'b1;
          st_d    = DS_SHIFT;
        end
      end
      DS_SHIFT: begin
        sh_d = {4'h0, sh_q[DATA_W-1:4]};
        if (nib_q == 3'h0) begin
          st_d = DS_IDLE;
        end else begin
          nib_d = nib_q - 3'h1;
        end
      end
      default: st_d = DS_IDLE;
    endcase
    cnt_d   = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    stall_d = (cnt_d == (PW+1)'(`DBG_FIFO_DEPTH));
  end

  // buffer entries, one generate loop
  for (genvar i = 0; i < `DBG_FIFO_DEPTH; i++) begin : g_ent
    always_ff @(posedge clock_in) begin
      if (reset_in) begin
        mem_q[i] <= '0;
        len_q[i] <= '0;
      end else begin
        mem_q[i] <= mem_d[i];
        len_q[i] <= len_d[i];
      end
    end
  end

  // buffer pointers and shifter registers
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wp_q    <= '0;
      rp_q    <= '0;
      cnt_q   <= '0;
      stall_q <= 1'b0;
      sh_q    <= '0;
      shlen_q <= '0;
      nib_q   <= '0;
      st_q    <= DS_IDLE;
    end else begin
      wp_q    <= wp_d;
      rp_q    <= rp_d;
      cnt_q   <= cnt_d;
      stall_q <= stall_d;
      sh_q    <= sh_d;
      shlen_q <= shlen_d;
      nib_q   <= nib_d;
      st_q    <= st_d;
    end
  end

  // trace outputs state
  dbg_nib_t pst_q, pst_d, dd_q, dd_d;
  logic     start_q, start_d;
  logic     tck_pos_q, tck_pos_d;
  logic     tck_neg_q;

  // status from pipeline, data from shifter or trigger status
  always_comb begin
    pst_d = `DBG_PST_CONT;
    if (halt_q) begin
      pst_d = `DBG_PST_HALT;
    end else if (instr_start_in) begin
      pst_d = (core_code_in != 4'h0) ? core_code_in
                                     : `DBG_PST_BEGIN;
    end else if (mark_now) begin
      pst_d = `DBG_PST_MARK | {2'b00, len_q[rp_q]};
    end
    dd_d = (st_q == DS_SHIFT) ? sh_q[3:0] : breakpoint_request_status_in;
    start_d = start_q ||
              (pst_d == `DBG_PST_RST_C) ||
              (pst_d == `DBG_PST_RST_D) ||
              (pst_d == `DBG_PST_HALT);
    tck_pos_d = tck_pos_q;
    if (start_q && !trace_quiet_in) begin
      tck_pos_d = ~tck_pos_q;
    end
    if (trace_quiet_in) begin
      pst_d = pst_q;
      dd_d  = dd_q;
    end
  end

  // trace registers, updated on every rising core edge
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pst_q     <= `DBG_PST_CONT;
      dd_q      <= 4'h0;
      start_q   <= 1'b0;
      tck_pos_q <= 1'b0;
    end else begin
      pst_q     <= pst_d;
      dd_q      <= dd_d;
      start_q   <= start_d;
      tck_pos_q <= tck_pos_d;
    end
  end

  // falling edge copy, puts trace clock rise mid window
  always_ff @(negedge clock_in) begin
    if (reset_in) begin
      tck_neg_q <= 1'b0;
    end else begin
      tck_neg_q <= tck_pos_q;
    end
  end

  // output drive
  assign debug_serial_out_out        = sout_q;
  assign serial_rx_bit_out           = rxb_q;
  assign serial_rx_valid_out         = rxv_q;
  assign core_halt_out               = halt_q;
  assign debug_irq_out               = irq_q;
  assign core_stall_out              = stall_q;
  assign processor_status_nibble_out = pst_q;
  assign debug_data_nibble_out       = dd_q;
  assign trace_clock_out             = ~(tck_pos_q ^ tck_neg_q);

  // checks on the block's outputs and internal signals
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  a_sclk_two_samples: assert property (
    $rose(debug_serial_clock_in) |-> !sclk_rise [*2])
    else $error("serial clock edge seen too early");
  a_sout_on_edge: assert property (
    sclk_rise |=> debug_serial_out_out == $past(serial_tx_bit_in) &&
                  serial_rx_valid_out)
    else $error("serial output not updated on edge");
  a_sout_held: assert property (
    !sclk_rise |=> $stable(debug_serial_out_out))
    else $error("serial output changed without edge");
  a_halt_status: assert property (
    (halt_q && !trace_quiet_in) |=>
      processor_status_nibble_out == `DBG_PST_HALT)
    else $error("halt not shown on status");
  a_irq_no_halt: assert property (
    (breakpoint_request_rise && breakpoint_to_interrupt_in && !halt_q && !pend_q)
      |=> debug_irq_out && !core_halt_out)
    else $error("interrupt mode misbehaved");
  a_quiet_freeze: assert property (
    trace_quiet_in |=> $stable(processor_status_nibble_out) &&
                       $stable(debug_data_nibble_out) &&
                       $stable(tck_pos_q))
    else $error("trace pins moved while quiet");
  a_clock_held: assert property (
    !start_q |=> $stable(tck_pos_q))
    else $error("trace clock ran before start");
  a_marker_first: assert property (
    (mark_now && !trace_quiet_in) ##1 !trace_quiet_in |->
      processor_status_nibble_out[3:2] == 2'b10 ##1
      debug_data_nibble_out == $past(sh_q[3:0]))
    else $error("marker or first nibble wrong");
  a_stall_full: assert property (
    cnt_q == (PW+1)'(`DBG_FIFO_DEPTH) |-> core_stall_out)
    else $error("no stall with full buffer");
  a_begin_code: assert property (
    (instr_start_in && core_code_in == 4'h0 && !halt_q &&
     !trace_quiet_in) |=> processor_status_nibble_out == `DBG_PST_BEGIN)
    else $error("begin code missing");

  c_halt:   cover property (halt_q ##1 resume_in);
  c_irq:    cover property (debug_irq_out);
  c_marker: cover property (mark_now ##1 st_q == DS_SHIFT);
  c_stall:  cover property (core_stall_out);
endmodule

//--- hw/dbg_sync.sv
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to clock_in
// Notes:   first stage feeds the second stage only
`timescale 1ns/100ps
module dbg_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clock_in,  // core clock
  input  wire logic             reset_in,  // sync reset, high
  input  wire logic [WIDTH-1:0] async_in,  // raw pins
  output logic      [WIDTH-1:0] sync_out   // synchronised level
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // next values of both stages
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // register both stages
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

//--- include/dbg_consts.svh
// Purpose: constants for the debug serial and trace pin block
// Assumes: processor clock of 40 MHz, serial clock at most a fifth of it
// Notes:   the list below summarises the block's behaviour
// Overview of operation
// - serial clock level valid after two equal samples; code edge-detects the two-stage synchroniser output without comparing samples
// - serial rising edge samples input, updates output
// - serial output comes from a register
// - breakpoint halts after instruction, status shows 0xF
// - interrupt mode raises debug interrupt instead
// - trace clock rises mid data window
// - quiet mode freezes trace pins, triggers live
// - trace clock waits for first 0xC/0xD/0xF status
// - data nibble shows breakpoint status or captures
// - write-debug-data operand always captured
// - both nibbles update every core cycle
// - status from pipeline, one-way pins, rising edge
// - byte-count marker one cycle before data
// - two-entry 32-bit buffer, low nibble first
// - core stalls while both entries full
// - 0x1 on first cycle, 0x0 afterwards
`ifndef DBG_CONSTS_SVH
`define DBG_CONSTS_SVH

`define DBG_CLK_PERIOD_NS 25
`define DBG_SCLK_RATIO    5
`define DBG_SYNC_STAGES   2
`define DBG_DATA_W        32
`define DBG_FIFO_DEPTH    2
`define DBG_PST_CONT      4'h0
`define DBG_PST_BEGIN     4'h1
`define DBG_PST_MARK      4'h8
`define DBG_PST_RST_C     4'hC
`define DBG_PST_RST_D     4'hD
`define DBG_PST_HALT      4'hF

`endif

//--- include/dbg_pins_pkg.sv
// Purpose: shared types for the debug serial and trace pin block
// Assumes: nothing beyond the constants header
// Notes:   nibble and length types used by ports and internals
package dbg_pins_pkg;
  typedef logic [3:0] dbg_nib_t;
  typedef logic [1:0] dbg_len_t;
  typedef enum logic {DS_IDLE, DS_SHIFT} dbg_shift_state_t;
endpackage

//--- verification/dbg_emu.sv
// Purpose: emulator model on the far side of the debug pins
// Assumes: serial clock of 200 ns, standing low outside frames
// Notes:   captures both trace nibbles on the rising trace clock
`timescale 1ns/100ps
module dbg_emu (
  input  wire logic               trace_clock_in, // trace clock pin
  input  wire dbg_pins_pkg::dbg_nib_t status_in,  // status nibble pin
  input  wire dbg_pins_pkg::dbg_nib_t data_in,    // data nibble pin
  output logic                    sclk_out,       // serial clock pin
  output logic                    sdata_out,      // serial data pin
  output dbg_pins_pkg::dbg_nib_t  cap_status_out, // status at trace rise
  output dbg_pins_pkg::dbg_nib_t  cap_data_out    // data at trace rise
);
  import dbg_pins_pkg::*;

  // lines idle before the first frame
  initial begin
    sclk_out  = 1'b0;
    sdata_out = 1'b0;
  end

  // trace nibbles are taken on the rising trace clock only
  always @(posedge trace_clock_in) begin
    cap_status_out <= status_in;
    cap_data_out   <= data_in;
  end

  // one serial bit, 100 ns low then 100 ns high, skewed off the core clock
  task automatic send_bit(input logic b);
    #7;
    sdata_out = b;
    #100;
    sclk_out = 1'b1;
    #100;
    sclk_out  = 1'b0;
    sdata_out = ~b; // released line shows the inverse
  endtask
endmodule

//--- verification/dbg_pins_bench.sv
// Purpose: self-checking bench for the debug serial and trace pins
// Assumes: 40 MHz core clock, emulator model on the pins
// Notes:   random words from an lfsr with fixed corner cases
`timescale 1ns/100ps
module dbg_pins_bench;
  import dbg_pins_pkg::*;
  logic        clock_in, reset_in, sclk, sdin, sout, tx, rxb, rxv;
  logic        breakpoint_request, b2i, quiet, cap_en, start, done, resume;
  logic        cap_v, wdd, halt, irq, stall, tclk;
  dbg_nib_t    code, bkst, status, data, cap_s, cap_dn;
  dbg_len_t    cap_n;
  logic [31:0] cap_d, snap;
  logic [15:0] lfsr_q;
  int          miscompares, tests_run;

  dbg_pins dut (.clock_in(clock_in), .reset_in(reset_in),
    .debug_serial_clock_in(sclk), .debug_serial_in_in(sdin),
    .debug_serial_out_out(sout), .serial_tx_bit_in(tx), .serial_rx_bit_out(rxb),
    .serial_rx_valid_out(rxv), .breakpoint_request_in(breakpoint_request),
    .breakpoint_to_interrupt_in(b2i), .trace_quiet_in(quiet),
    .capture_enable_in(cap_en), .instr_start_in(start), .core_code_in(code),
    .instr_done_in(done), .resume_in(resume), .breakpoint_request_status_in(bkst),
    .capture_valid_in(cap_v), .capture_data_in(cap_d), .capture_bytes_in(cap_n),
    .write_debug_data_instr_valid_in(wdd), .core_halt_out(halt), .debug_irq_out(irq),
    .core_stall_out(stall), .trace_clock_out(tclk),
    .processor_status_nibble_out(status), .debug_data_nibble_out(data));

  dbg_emu emu (.trace_clock_in(tclk), .status_in(status), .data_in(data),
    .sclk_out(sclk), .sdata_out(sdin), .cap_status_out(cap_s), .cap_data_out(cap_dn));

  // core clock
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // stimulus source and expectation helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic dbg_nib_t marker_of(input dbg_len_t n);
    return 4'h8 + {2'h0, n};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic ran_out();
    miscompares++;
    $display("BAD %0t wait ran out", $time);
    finish_test();
  endtask
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wait_hi(ref logic s, input int bound);
    for (int n = 0; n < bound && s !== 1'b1; n++) cyc();
    if (s !== 1'b1) ran_out();
  endtask
  task automatic wait_nib(input dbg_nib_t v, input int bound);
    for (int n = 0; n < bound && status !== v; n++) cyc();
    if (status !== v) ran_out();
  endtask
  // trace clock low after the core rise, high after the core fall
  task automatic trace_mid();
    chk(tclk, 1'b0);
    #12.5;
    chk(tclk, 1'b1);
    cyc();
  endtask
  task automatic push(input logic [31:0] w, input dbg_len_t n, input logic wd);
    cap_d = w;
    cap_n = n;
    cap_v = ~wd;
    wdd   = wd;
    cyc();
    cap_v = 1'b0;
    wdd   = 1'b0;
  endtask
  task automatic expect_word(input logic [31:0] w, input dbg_len_t n);
    wait_nib(marker_of(n), 24);
    for (int i = 0; i < 2 * (n + 1); i++) begin
      cyc();
      chk(data, w[4*i +: 4]);
    end
  endtask
  task automatic serial_rx(input logic b);
    wait_hi(rxv, 14);
    chk(rxb, b);
    chk(sout, tx);
    cyc();
    chk(rxv, 1'b0);
  endtask
  task automatic halt_cycle();
    breakpoint_request = 1'b1;
    done = 1'b1;
    cyc(2);
    chk(halt, 1'b0);
    cyc();
    chk(halt, 1'b1);
    cyc();
  endtask
  task automatic leave_halt();
    breakpoint_request = 1'b0;
    done = 1'b0;
    cyc(3);
    resume = 1'b1;
    cyc();
    resume = 1'b0;
    cyc(2);
    chk(halt, 1'b0);
  endtask

  // main sequence
  initial begin
    {tx, breakpoint_request, b2i, quiet, cap_en, start, done, resume, cap_v, wdd} = 10'h000;
    {code, bkst, cap_n, cap_d} = 42'h0;
    miscompares = 0;
    tests_run   = 0;
    lfsr_q      = 16'h0051;
    reset_in    = 1'b1;
    cyc(3);
    reset_in = 1'b0;
    chk({tclk, status, sout, rxv, halt, irq, stall}, 10'h200);
    // plain and special instruction starts, then continuation
    start = 1'b1;
    cyc();
    chk(status, 4'h1);
    code = 4'h5;
    cyc();
    chk(status, 4'h5);
    start = 1'b0;
    code  = 4'h0;
    cyc();
    chk(status, 4'h0);
    chk(tclk, 1'b1);
    #12.5;
    chk(tclk, 1'b1);
    cyc();
    // one serial frame of random bits
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      tx     = lfsr_q[1];
      fork
        emu.send_bit(lfsr_q[0]);
        serial_rx(lfsr_q[0]);
      join
      // back onto the stimulus grid just after a core rise
      cyc();
    end
    // halt starts the trace clock
    halt_cycle();
    chk(status, 4'hF);
    cyc(3);
    trace_mid();
    chk(cap_s, 4'hF);
    leave_halt();
    // interrupt mode raises a pulse and no halt
    b2i  = 1'b1;
    breakpoint_request = 1'b1;
    done = 1'b1;
    wait_hi(irq, 6);
    cyc();
    chk({irq, halt}, 2'h0);
    // drop the pin first so its synchronised level cannot arm a halt
    {breakpoint_request, done} = 2'h0;
    cyc(3);
    b2i = 1'b0;
    // default data nibble follows trigger status
    lfsr_q = lfsr_next(lfsr_q);
    bkst   = lfsr_q[3:0];
    cyc(2);
    chk(data, bkst);
    chk(cap_dn, bkst);
    // random captures, both byte-count extremes, write-data with capture off
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      snap   = {lfsr_q, lfsr_next(lfsr_q)};
      cap_en = (i != 7);
      push(snap, (i < 2) ? 2'(i * 3) : lfsr_q[5:4], i == 7);
      expect_word(snap, cap_n);
    end
    // two entries held back by instruction starts stall the core
    cap_en = 1'b1;
    start  = 1'b1;
    push(32'h89AB_CDEF, 2'h3, 1'b0);
    cyc();
    push(32'h0000_0074, 2'h0, 1'b0);
    wait_hi(stall, 4);
    start = 1'b0;
    expect_word(32'h89AB_CDEF, 2'h3);
    expect_word(32'h0000_0074, 2'h0);
    chk(stall, 1'b0);
    // quiet mode freezes trace pins while triggers still halt
    quiet = 1'b1;
    cyc();
    snap = {23'h0, tclk, status, data};
    push(32'h1234_5678, 2'h3, 1'b0);
    halt_cycle();
    for (int i = 0; i < 10; i++) begin
      chk({23'h0, tclk, status, data}, snap);
      cyc();
    end
    leave_halt();
    quiet = 1'b0;
    cyc(2);
    trace_mid();
    // second reset, trace clock restarted by a reset status code
    reset_in = 1'b1;
    cyc(3);
    reset_in = 1'b0;
    chk(tclk, 1'b1);
    start = 1'b1;
    code  = 4'hC;
    cyc();
    chk(status, 4'hC);
    start = 1'b0;
    code  = 4'h0;
    cyc(2);
    trace_mid();
    finish_test();
  end
endmodule
